// ---- include/baud_ctrl_pkg.sv ----
// Purpose: Shared constants and types for the serial port baud rate front end
// Assumes: 8-bit register port on mclk, synchronous active-high reset
// Notes: Offsets are word indexes on the plain register port
package baud_ctrl_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int DIV_W = 13;
   localparam int OVS = 16;
   // Register offsets
   localparam logic [3:0] OFF_BDH = 4'h0;
   localparam logic [3:0] OFF_BDL = 4'h1;
   localparam logic [3:0] OFF_CTRL = 4'h2;
   localparam logic [3:0] OFF_OPT = 4'h3;
   localparam logic [3:0] OFF_IRQ_STAT = 4'h4;
   localparam logic [3:0] OFF_IRQ_MASK = 4'h5;
   // Field positions
   localparam int BDH_BRK_IE_BIT = 7;
   localparam int BDH_EDGE_IE_BIT = 6;
   localparam int CTRL_RX_ON_BIT = 2;
   localparam int CTRL_TX_ON_BIT = 3;
   localparam int OPT_PIN_POS_BIT = 0;
   localparam int STAT_BRK_BIT = 0;
   localparam int STAT_EDGE_BIT = 1;
   // Reset values and last oversampling count
   localparam logic [7:0] BDH_RST = 8'h00;
   localparam logic [7:0] BDL_RST = 8'h04;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [3:0] OVS_LAST = 4'hf;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic txd;
      logic rxd;
   } serial_pins_t;

   typedef enum logic [1:0] {
      GEN_OFF = 2'b00,
      GEN_ARMED = 2'b01,
      GEN_RUN = 2'b10
   } gen_state_t;
endpackage : baud_ctrl_pkg

// ---- tb/baud_ctrl_assertions.sv ----
// Purpose: Port checks for the baud rate front end
// Assumes: Register writes are seen on req the edge they are taken
// Notes: Shadows the few register bits the checks need
`timescale 1ns/1ns
module baud_ctrl_assertions (
   input wire logic mclk,
   input wire logic rst,
   input baud_ctrl_pkg::reg_req_t req,
   input wire logic [baud_ctrl_pkg::DATA_W-1:0] rdata,
   input wire logic line_break_detect_flag,
   input wire logic receive_edge_flag,
   input wire logic second_port_transmit_pin,
   input wire logic second_port_receive_pin,
   input baud_ctrl_pkg::serial_pins_t port_f_out,
   input baud_ctrl_pkg::serial_pins_t port_f_oe,
   input baud_ctrl_pkg::serial_pins_t port_f_in,
   input baud_ctrl_pkg::serial_pins_t port_e_out,
   input baud_ctrl_pkg::serial_pins_t port_e_oe,
   input baud_ctrl_pkg::serial_pins_t port_e_in,
   input wire logic rx_on_switch,
   input wire logic tx_on_switch,
   input wire logic ovs_tick,
   input wire logic break_irq,
   input wire logic edge_irq,
   input wire logic irq
);
   import baud_ctrl_pkg::*;
   logic [7:0] bdh_r;
   logic [12:0] div_r;
   logic sel_r;
   logic [5:0] calm_r;
   logic [5:0] gap_r;
   // Shadow of the live divisor: high half only lands with a low write
   always_ff @(posedge mclk) begin
      if (rst) begin
         bdh_r <= BDH_RST;
         div_r <= {5'h00, BDL_RST};
         sel_r <= 1'b0;
      end else if (req.wr) begin
         if (req.addr == OFF_BDH) bdh_r <= req.wdata;
         if (req.addr == OFF_BDL) div_r <= {bdh_r[4:0], req.wdata};
         if (req.addr == OFF_OPT) sel_r <= req.wdata[OPT_PIN_POS_BIT];
      end
   end
   // Spacing is only judged once setup has settled, since reloads lag a write
   always_ff @(posedge mclk) begin
      if (rst || (req.wr && (req.addr == OFF_BDL || req.addr == OFF_CTRL))) calm_r <= 6'h00;
      else if (calm_r != 6'h3f) calm_r <= calm_r + 6'h01;
      if (rst || ovs_tick) gap_r <= 6'h00;
      else if (gap_r != 6'h3f) gap_r <= gap_r + 6'h01;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_idle; ((!rx_on_switch && !tx_on_switch) || div_r == 13'h0000) [*4]; endsequence
   sequence s_steady; ovs_tick && calm_r >= 6'h28 && div_r < 13'h0010; endsequence
   property p_off; s_idle |-> !ovs_tick; endproperty
   a_off: assert property (p_off) else $error("tick while idle");
   property p_gap; s_steady |-> 13'(gap_r) == div_r - 13'h0001; endproperty
   a_gap: assert property (p_gap) else $error("tick spacing wrong");
   property p_brk; break_irq == (bdh_r[BDH_BRK_IE_BIT] && line_break_detect_flag); endproperty
   a_brk: assert property (p_brk) else $error("break request wrong");
   property p_edge; edge_irq == (bdh_r[BDH_EDGE_IE_BIT] && receive_edge_flag); endproperty
   a_edge: assert property (p_edge) else $error("edge request wrong");
   property p_irq; (break_irq || edge_irq) |-> irq; endproperty
   a_irq: assert property (p_irq) else $error("request not on irq");
   property p_rdata; !$past(req.rd) |-> rdata == 8'h00; endproperty
   a_rdata: assert property (p_rdata) else $error("read data outside slot");
   property p_tx; port_f_oe.txd == !sel_r && port_e_oe.txd == sel_r
      && (sel_r ? port_e_out.txd : port_f_out.txd) == second_port_transmit_pin; endproperty
   a_tx: assert property (p_tx) else $error("transmit pin route wrong");
   property p_rx; second_port_receive_pin == (sel_r ? port_e_in.rxd : port_f_in.rxd); endproperty
   a_rx: assert property (p_rx) else $error("receive pin route wrong");
endmodule : baud_ctrl_assertions
bind baud_ctrl baud_ctrl_assertions i_chk (.mclk, .rst, .req, .rdata, .line_break_detect_flag,
   .receive_edge_flag, .second_port_transmit_pin, .second_port_receive_pin, .port_f_out,
   .port_f_oe, .port_f_in, .port_e_out, .port_e_oe, .port_e_in, .rx_on_switch, .tx_on_switch,
   .ovs_tick, .break_irq, .edge_irq, .irq);

// ---- tb/baud_ctrl_bench.sv ----
// Purpose: Self-checking bench for the baud rate front end
// Assumes: Plain register port, one clock at 50 MHz
// Notes: Rates are judged by measuring bit_tick spacing
`timescale 1ns/1ns
module baud_ctrl_bench;
   import baud_ctrl_pkg::*;
   logic mclk = 1'b0, rst = 1'b1, brk = 1'b0, edg = 1'b0, txp = 1'b0, rxl = 1'b1;
   reg_req_t req = '0;
   serial_pins_t f_out, f_oe, f_in, e_out, e_oe, e_in;
   logic [7:0] rdata;
   logic rxp, ovs, bt, brk_irq, edg_irq, irq, rxo, txo;
   int errors = 0, num_checks = 0;
   baud_ctrl i_dut (.mclk, .rst, .req, .rdata, .line_break_detect_flag(brk),
      .receive_edge_flag(edg), .second_port_transmit_pin(txp), .second_port_receive_pin(rxp),
      .port_f_out(f_out), .port_f_oe(f_oe), .port_f_in(f_in), .port_e_out(e_out),
      .port_e_oe(e_oe), .port_e_in(e_in), .rx_on_switch(rxo), .tx_on_switch(txo), .ovs_tick(ovs),
      .bit_tick(bt), .break_irq(brk_irq), .edge_irq(edg_irq), .irq);
   serial_peer i_peer (.mclk, .rx_level(rxl), .f_oe, .e_oe, .f_in, .e_in);
   // Free-running bus clock
   initial forever #10 mclk = ~mclk;
   task chk(input string nm, input logic [12:0] exp, input logic [12:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk
   task op(input logic [3:0] a, input logic [7:0] d, input logic w);
      @(posedge mclk);
      req <= '{a, d, w, !w};
   endtask : op
   task wr(input logic [3:0] a, input logic [7:0] d);
      op(a, d, 1'b1);
      @(posedge mclk);
      req <= '0;
      #1;
   endtask : wr
   task rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
      op(a, 8'h00, 1'b0);
      @(posedge mclk);
      req <= '0;
      #1;
      chk(nm, {5'h00, exp}, {5'h00, rdata});
   endtask : rd
   // Third gap is measured so a reload in flight cannot skew it
   task period(input logic [12:0] exp);
      int n;
      repeat (3) begin
         n = 0;
         do begin
            @(posedge mclk);
            #1;
            n++;
         end while (bt !== 1'b1 && n < 9000);
      end
      chk("bit period", exp, 13'(n));
   endtask : period
   task quiet(input string nm);
      int k;
      k = 0;
      repeat (64) begin
         @(posedge mclk);
         #1;
         // Generator stops one cycle after the switch write, so one late tick is legal
         if (k < 60 && ovs !== 1'b0 && k >= 2) k = -100;
         k++;
      end
      chk(nm, 13'h0040, 13'(k));
   endtask : quiet
   task tally_and_finish;
      if (errors == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish
   // Hang guard, well past the longest divisor sweep
   initial begin
      repeat (60000) @(posedge mclk);
      errors++;
      tally_and_finish();
   end
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      rd(OFF_BDH, BDH_RST, "bdh reset");
      rd(OFF_BDL, BDL_RST, "bdl reset");
      rd(4'hf, 8'h00, "unmapped");
      quiet("idle after reset");
      wr(OFF_CTRL, 8'h04);
      chk("rx on", 13'h1, rxo);
      chk("tx on", 13'h0, txo);
      rd(OFF_CTRL, 8'h04, "ctrl");
      wr(OFF_BDL, 8'h02);
      period(13'd32);
      wr(OFF_BDH, 8'h01);
      period(13'd32);
      wr(OFF_BDL, 8'h02);
      period(13'd4128);
      op(OFF_BDH, 8'h00, 1'b1);
      wr(OFF_BDL, 8'h03);
      period(13'd48);
      wr(OFF_BDL, 8'h00);
      quiet("zero divisor");
      wr(OFF_CTRL, 8'h08);
      chk("rx on", 13'h0, rxo);
      chk("tx on", 13'h1, txo);
      wr(OFF_BDL, 8'h01);
      period(13'd16);
      wr(OFF_CTRL, 8'h00);
      quiet("switches off");
      @(posedge mclk);
      brk <= 1'b1;
      edg <= 1'b1;
      wr(OFF_BDH, 8'h80);
      chk("break irq", 13'h1, brk_irq);
      chk("edge irq", 13'h0, edg_irq);
      wr(OFF_BDH, 8'h40);
      chk("break irq", 13'h0, brk_irq);
      chk("edge irq", 13'h1, edg_irq);
      rd(OFF_IRQ_STAT, 8'h03, "status");
      rd(OFF_IRQ_STAT, 8'h00, "status cleared");
      wr(OFF_BDH, 8'h00);
      chk("irq", 13'h0, irq);
      brk <= 1'b0;
      wr(OFF_IRQ_MASK, 8'h01);
      rd(OFF_IRQ_MASK, 8'h01, "mask");
      brk <= 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      chk("masked irq", 13'h1, irq);
      rd(OFF_IRQ_STAT, 8'h01, "status");
      chk("irq cleared", 13'h0, irq);
      @(posedge mclk);
      txp <= 1'b1;
      rxl <= 1'b0;
      #1;
      chk("f txd", 13'h1, f_out.txd);
      chk("rx pin", 13'h0, rxp);
      wr(OFF_OPT, 8'h01);
      chk("e txd", 13'h1, e_out.txd);
      chk("f oe", 13'h0, f_oe.txd);
      chk("e oe", 13'h1, e_oe.txd);
      rd(OFF_OPT, 8'h01, "opt");
      chk("rx pin", 13'h0, rxp);
      tally_and_finish();
   end
endmodule : baud_ctrl_bench

// ---- tb/serial_peer.sv ----
// Purpose: Remote serial device on the second port pins
// Assumes: It sits on whichever pair carries an enabled transmit driver
// Notes: Lines nobody drives wander every cycle so stale values never pass
`timescale 1ns/1ns
module serial_peer (
   input wire logic mclk,
   input wire logic rx_level,
   input baud_ctrl_pkg::serial_pins_t f_oe,
   input baud_ctrl_pkg::serial_pins_t e_oe,
   output baud_ctrl_pkg::serial_pins_t f_in,
   output baud_ctrl_pkg::serial_pins_t e_in
);
   logic wob_r = 1'b0;
   // Wandering level for released lines
   always_ff @(posedge mclk) wob_r <= !wob_r;
   // Drive receive only on the pair that is in use
   assign f_in = '{txd: wob_r, rxd: f_oe.txd ? rx_level : wob_r};
   assign e_in = '{txd: wob_r, rxd: e_oe.txd ? rx_level : wob_r};
endmodule : serial_peer

// ---- verilog/baud_ctrl.sv ----
// Purpose: Baud divisor registers, interrupt gating and pin position of the serial port
// Assumes: Register port strobes are one cycle; rdata valid the cycle after rd
// Notes: Framing and shifting live elsewhere; this block supplies their ticks
// Function
// - Second port pins: sel 0 gives port F bits 0/1, sel 1 port E 6/7
// - High divisor write buffers bits 4:0, its enable bits 7:6 apply at once; low divisor write commits both halves
// - Low divisor resets nonzero; generator idle until rx or tx enabled
// - Divisor zero stops the generator completely
// - Bit rate equals bus clock over sixteen times divisor
// - Divisor bits 12:8 in high bits 4:0, bits 7:0 in low
// - High bit 7 gates line-break flag onto interrupt request
// - High bit 6 gates receive-edge flag onto interrupt request
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ns
module baud_ctrl #(
   parameter int DIV_W = 13
) (
   input wire logic mclk,
   input wire logic rst,
   input baud_ctrl_pkg::reg_req_t req,
   output logic [baud_ctrl_pkg::DATA_W-1:0] rdata,
   input wire logic line_break_detect_flag,
   input wire logic receive_edge_flag,
   input wire logic second_port_transmit_pin,
   output logic second_port_receive_pin,
   output baud_ctrl_pkg::serial_pins_t port_f_out,
   output baud_ctrl_pkg::serial_pins_t port_f_oe,
   input baud_ctrl_pkg::serial_pins_t port_f_in,
   output baud_ctrl_pkg::serial_pins_t port_e_out,
   output baud_ctrl_pkg::serial_pins_t port_e_oe,
   input baud_ctrl_pkg::serial_pins_t port_e_in,
   output logic rx_on_switch,
   output logic tx_on_switch,
   output logic ovs_tick,
   output logic bit_tick,
   output logic break_irq,
   output logic edge_irq,
   output logic irq
);
   import baud_ctrl_pkg::*;

   logic [7:0] bdh_r;
   logic [4:0] hi_buf_r;
   logic [DIV_W-1:0] baud_divisor_value;
   logic [7:0] bdl_r;
   logic [7:0] ctrl_r;
   logic pin_sel_r;
   logic [1:0] stat_r;
   logic [1:0] stat_nxt;
   logic [1:0] mask_r;
   logic brk_q_r;
   logic edge_q_r;
   logic [1:0] event_now;
   gen_state_t gen_r;
   gen_state_t gen_nxt;
   logic wr_bdh;
   logic wr_bdl;
   logic wr_ctrl;
   logic wr_opt;
   logic wr_mask;
   logic rd_stat;

   // Address decode for writes
   always_comb begin
      wr_bdh = 1'b0;
      wr_bdl = 1'b0;
      wr_ctrl = 1'b0;
      wr_opt = 1'b0;
      wr_mask = 1'b0;
      if (req.wr && req.addr == OFF_BDH) begin
         wr_bdh = 1'b1;
      end else if (req.wr && req.addr == OFF_BDL) begin
         wr_bdl = 1'b1;
      end else if (req.wr && req.addr == OFF_CTRL) begin
         wr_ctrl = 1'b1;
      end else if (req.wr && req.addr == OFF_OPT) begin
         wr_opt = 1'b1;
      end else if (req.wr && req.addr == OFF_IRQ_MASK) begin
         wr_mask = 1'b1;
      end
   end
   assign rd_stat = req.rd && (req.addr == OFF_IRQ_STAT);

   // Enable bits and buffered high half; working high half loads from the buffer on a low write
   always_ff @(posedge mclk) begin
      if (rst) begin
         bdh_r <= BDH_RST;
         hi_buf_r <= BDH_RST[4:0];
      end else if (wr_bdh) begin
         bdh_r[7:6] <= req.wdata[7:6];
         hi_buf_r <= req.wdata[4:0];
      end else if (wr_bdl) begin
         bdh_r[4:0] <= hi_buf_r;
      end
   end

   // Low half; its write also commits the buffered high half above
   always_ff @(posedge mclk) begin
      if (rst) begin
         bdl_r <= BDL_RST;
      end else if (wr_bdl) begin
         bdl_r <= req.wdata;
      end
   end

   // Thirteen-bit divisor assembled from both registers
   assign baud_divisor_value = {bdh_r[4:0], bdl_r};

   // Receiver and transmitter switches
   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_r <= CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= req.wdata;
      end
   end
   assign rx_on_switch = ctrl_r[CTRL_RX_ON_BIT];
   assign tx_on_switch = ctrl_r[CTRL_TX_ON_BIT];

   // Pin position select, default port F
   always_ff @(posedge mclk) begin
      if (rst) begin
         pin_sel_r <= 1'b0;
      end else if (wr_opt) begin
         pin_sel_r <= req.wdata[OPT_PIN_POS_BIT];
      end
   end

   // Generator stays off from reset until either switch is first written to one,
   // then follows the switches; a zero divisor parks it regardless
   always_comb begin
      gen_nxt = gen_r;
      case (gen_r)
         GEN_OFF: begin
            if (rx_on_switch || tx_on_switch) begin
               gen_nxt = GEN_ARMED;
            end
         end
         GEN_ARMED: begin
            if (baud_divisor_value != '0) begin
               gen_nxt = GEN_RUN;
            end
         end
         GEN_RUN: begin
            if (baud_divisor_value == '0) begin
               gen_nxt = GEN_ARMED;
            end else if (!(rx_on_switch || tx_on_switch)) begin
               gen_nxt = GEN_OFF;
            end
         end
         default: gen_nxt = GEN_OFF;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         gen_r <= GEN_OFF;
      end else begin
         gen_r <= gen_nxt;
      end
   end

   // Counter reloads at the divisor; sixteen ticks per bit
   baud_tick_gen #(
      .DIV_W(DIV_W)
   ) u_tick (
      .mclk(mclk),
      .rst(rst),
      .run(gen_r == GEN_RUN),
      .div(baud_divisor_value),
      .ovs_tick(ovs_tick),
      .bit_tick(bit_tick)
   );

   // Second port pin steering
   pin_route u_route (
      .sel(pin_sel_r),
      .txd(second_port_transmit_pin),
      .rxd(second_port_receive_pin),
      .f_out(port_f_out),
      .f_oe(port_f_oe),
      .f_in(port_f_in),
      .e_out(port_e_out),
      .e_oe(port_e_oe),
      .e_in(port_e_in)
   );

   // Level requests gated by the enable bits in the high divisor register
   assign break_irq = bdh_r[BDH_BRK_IE_BIT] && line_break_detect_flag;
   assign edge_irq = bdh_r[BDH_EDGE_IE_BIT] && receive_edge_flag;

   // Rising edges of the flags are the events for the sticky status
   always_ff @(posedge mclk) begin
      if (rst) begin
         brk_q_r <= 1'b0;
         edge_q_r <= 1'b0;
      end else begin
         brk_q_r <= line_break_detect_flag;
         edge_q_r <= receive_edge_flag;
      end
   end
   assign event_now[STAT_BRK_BIT] = line_break_detect_flag && !brk_q_r;
   assign event_now[STAT_EDGE_BIT] = receive_edge_flag && !edge_q_r;

   // Read clears, but an event in the same cycle survives the clear
   always_comb begin
      stat_nxt = rd_stat ? 2'h0 : stat_r;
      stat_nxt = stat_nxt | event_now;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         stat_r <= 2'h0;
      end else begin
         stat_r <= stat_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         mask_r <= MASK_RST[1:0];
      end else if (wr_mask) begin
         mask_r <= req.wdata[1:0];
      end
   end

   // Single level interrupt: gated flags or unmasked sticky events
   assign irq = break_irq || edge_irq || |(stat_r & mask_r);

   // Read data registered, valid the cycle after the strobe only
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (!req.rd) begin
         rdata <= 8'h00;
      end else if (req.addr == OFF_BDH) begin
         rdata <= {bdh_r[7:6], 1'b0, bdh_r[4:0]};
      end else if (req.addr == OFF_BDL) begin
         rdata <= bdl_r;
      end else if (req.addr == OFF_CTRL) begin
         rdata <= ctrl_r;
      end else if (req.addr == OFF_OPT) begin
         rdata <= {7'h00, pin_sel_r};
      end else if (req.addr == OFF_IRQ_STAT) begin
         rdata <= {6'h00, stat_r};
      end else if (req.addr == OFF_IRQ_MASK) begin
         rdata <= {6'h00, mask_r};
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule : baud_ctrl

// ---- verilog/baud_tick_gen.sv ----
// Purpose: Modulo counter giving the oversampling tick and the bit tick
// Assumes: div is stable or a change applies at once to the count already in progress
// Notes: Counter frozen at zero while disabled to save switching
`timescale 1ns/1ns
module baud_tick_gen #(
   parameter int DIV_W = 13
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic run,
   input wire logic [DIV_W-1:0] div,
   output logic ovs_tick,
   output logic bit_tick
);
   import baud_ctrl_pkg::*;
   logic [DIV_W-1:0] cnt_r;
   logic [3:0] ovs_r;
   logic zero_div;

   assign zero_div = (div == '0);

   // Divide mclk by div; a held counter draws no switching current
   always_ff @(posedge mclk) begin
      if (rst || !run || zero_div) begin
         cnt_r <= '0;
      end else if (cnt_r >= div - DIV_W'(1)) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + DIV_W'(1);
      end
   end

   // Tick pulse registered so downstream sees a clean one-cycle strobe
   always_ff @(posedge mclk) begin
      if (rst) begin
         ovs_tick <= 1'b0;
      end else begin
         ovs_tick <= run && !zero_div && (cnt_r >= div - DIV_W'(1));
      end
   end

   // Sixteen oversampling ticks make one bit time
   always_ff @(posedge mclk) begin
      if (rst || !run || zero_div) begin
         ovs_r <= '0;
         bit_tick <= 1'b0;
      end else begin
         bit_tick <= ovs_tick && (ovs_r == OVS_LAST);
         if (ovs_tick) begin
            ovs_r <= ovs_r + 4'h1;
         end
      end
   end
endmodule : baud_tick_gen

// ---- verilog/pin_route.sv ----
// Purpose: Route second port transmit and receive onto one of two pin pairs
// Assumes: Unselected pins are left undriven and released to general I/O
// Notes: Receive from the unselected pair is ignored
`timescale 1ns/1ns
module pin_route (
   input wire logic sel,
   input wire logic txd,
   output logic rxd,
   output baud_ctrl_pkg::serial_pins_t f_out,
   output baud_ctrl_pkg::serial_pins_t f_oe,
   input baud_ctrl_pkg::serial_pins_t f_in,
   output baud_ctrl_pkg::serial_pins_t e_out,
   output baud_ctrl_pkg::serial_pins_t e_oe,
   input baud_ctrl_pkg::serial_pins_t e_in
);
   import baud_ctrl_pkg::*;
   // Port F bits 0/1 when sel is 0, port E bits 6/7 when sel is 1
   always_comb begin
      f_out = '{txd: txd, rxd: 1'b0};
      e_out = '{txd: txd, rxd: 1'b0};
      f_oe = '{txd: !sel, rxd: 1'b0};
      e_oe = '{txd: sel, rxd: 1'b0};
      rxd = sel ? e_in.rxd : f_in.rxd;
   end
endmodule : pin_route
